// ===== hw/opctl_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - First flag bit7, zero when disabled
// - Calibration mode shows first amplifier output
// - Second flag bit5, zero when disabled
// - Calibration mode shows second amplifier output
// - Bit7 selects normal or calibration mode
// - Bit6 selects negative or positive reference
// - Calibration only acts with reference bit set
// - Bit5 enables the amplifier
// - Bits4..0 hold the trim code
// - Low pins: bit2 second neg, bit1 first neg
// - Upper pins: bits3..0 pos/out switches
// - Unimplemented bits read as zero
module opctl_regs #(
  parameter int NPINS = opctl_pkg::NUM_PINS  // Analog pin count
) (
  input  wire logic                   ref_clk,     // 50 MHz clock
  input  wire logic                   rst,         // Sync reset, high
  input  wire logic                   wb_cyc_i,    // Wishbone cycle
  input  wire logic                   wb_stb_i,    // Wishbone strobe
  input  wire logic                   wb_we_i,     // Write enable
  input  wire logic [7:0]             wb_adr_i,    // Byte address
  input  wire logic [3:0]             wb_sel_i,    // Byte selects
  input  wire logic [31:0]            wb_dat_i,    // Write data
  output logic      [31:0]            wb_dat_o,    // Read data
  output logic                        wb_ack_o,    // Acknowledge
  input  wire logic                   amp1_out,    // First amplifier comparator level
  input  wire logic                   amp2_out,    // Second amplifier comparator level
  output opctl_pkg::opctl_amp_type    amp1_ctl,    // First amplifier controls
  output opctl_pkg::opctl_amp_type    amp2_ctl,    // Second amplifier controls
  output logic      [7:0]             ref_ctl,     // Reference control bits
  output logic      [7:0]             amp3_ctl,    // Third amplifier bits
  output logic      [7:0]             conv_sw,     // Converter switches
  output opctl_pkg::opctl_pin_type [NPINS-1:0] pin_sw // Per-pin amplifier switches
);
  typedef struct packed {
    logic [7:0]             ref_r;
    logic [7:0]             amp1_r;
    logic [7:0]             amp2_r;
    logic [7:0]             amp3_r;
    logic [7:0]             conv_r;
    logic [NPINS-1:0][7:0]  pin_r;
    logic [31:0]            dat_r;
    logic                   ack_r;
    opctl_pkg::opctl_amp_type a1_r;
    opctl_pkg::opctl_amp_type a2_r;
    opctl_pkg::opctl_pin_type [NPINS-1:0] ps_r;
  } opctl_state_type;

  opctl_state_type st_r;
  opctl_state_type st_nxt;
  logic            flag1;
  logic            flag2;

  // Writable mask of a pin switch register by group
  function automatic logic [7:0] pin_mask(input int idx);
    if (idx < opctl_pkg::LOW_PINS) begin
      pin_mask = opctl_pkg::MASK_PIN_LOW;
    end else if (idx <= opctl_pkg::MID_LAST) begin
      pin_mask = opctl_pkg::MASK_PIN_MID;
    end else begin
      pin_mask = opctl_pkg::MASK_PIN_HIGH;
    end
  endfunction : pin_mask

  // Decode an amplifier control byte
  function automatic opctl_pkg::opctl_amp_type amp_decode(input logic [7:0] v);
    amp_decode.enable      = v[opctl_pkg::BIT_ENABLE];
    amp_decode.cal_mode    = v[opctl_pkg::BIT_CAL_MODE];
    amp_decode.cal_ref_pos = v[opctl_pkg::BIT_CAL_REF];
    // Calibration switches only close with positive reference chosen
    amp_decode.cal_active  = v[opctl_pkg::BIT_CAL_MODE] & v[opctl_pkg::BIT_CAL_REF]
                             & v[opctl_pkg::BIT_ENABLE];
    amp_decode.trim_code   = v[opctl_pkg::TRIM_MSB:0];
  endfunction : amp_decode

  // Masked byte-lane 0 write
  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] d,
                                         input logic [7:0] m);
    wr_byte = (old & ~m) | (d & m);
  endfunction : wr_byte

  // Comparator flags, synchronised and qualified
  opctl_flag u_flag1 (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .cmp_async (amp1_out),
    .enable    (st_r.amp1_r[opctl_pkg::BIT_ENABLE]),
    .cal_mode  (st_r.amp1_r[opctl_pkg::BIT_CAL_MODE]),
    .flag      (flag1)
  );
  opctl_flag u_flag2 (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .cmp_async (amp2_out),
    .enable    (st_r.amp2_r[opctl_pkg::BIT_ENABLE]),
    .cal_mode  (st_r.amp2_r[opctl_pkg::BIT_CAL_MODE]),
    .flag      (flag2)
  );

  // Bus slave, one wait-free ack per request then a gap
  always_comb begin
    logic       req;
    logic       wr;
    logic [5:0] idx;
    logic [7:0] rb;
    logic [7:0] wd;
    req    = 1'b0;
    wr     = 1'b0;
    idx    = 6'h00;
    rb     = 8'h00;
    wd     = 8'h00;
    st_nxt = st_r;
    req    = wb_cyc_i & wb_stb_i & ~st_r.ack_r;
    wr     = req & wb_we_i & wb_sel_i[0];
    idx    = wb_adr_i[7:2];
    wd     = wb_dat_i[7:0];
    st_nxt.ack_r = req;
    // Read mux; flags come live, unused bits zero
    case (idx)
      opctl_pkg::IDX_REF_FLAG: begin
        rb = st_r.ref_r & opctl_pkg::MASK_REF_FLAG;
        rb[opctl_pkg::BIT_FLAG_ONE] = flag1;
      end
      opctl_pkg::IDX_AMP_ONE:   rb = st_r.amp1_r;
      opctl_pkg::IDX_AMP_TWO:   rb = st_r.amp2_r;
      opctl_pkg::IDX_AMP_THREE: begin
        rb = st_r.amp3_r & opctl_pkg::MASK_AMP_THREE;
        rb[opctl_pkg::BIT_FLAG_TWO] = flag2;
      end
      opctl_pkg::IDX_CONV_SW:   rb = st_r.conv_r & opctl_pkg::MASK_CONV_SW;
      default: begin
        rb = 8'h00;
        for (int i = 0; i < NPINS; i++) begin
          if (idx == opctl_pkg::IDX_PIN_BASE + 6'(i)) begin
            rb = st_r.pin_r[i] & pin_mask(i);
          end
        end
      end
    endcase
    st_nxt.dat_r = req ? {24'h000000, rb} : opctl_pkg::READ_ZERO;
    // Writes land in lane 0 only
    if (wr) begin
      case (idx)
        opctl_pkg::IDX_REF_FLAG:  st_nxt.ref_r  = wr_byte(st_r.ref_r, wd, opctl_pkg::MASK_REF_FLAG);
        opctl_pkg::IDX_AMP_ONE:   st_nxt.amp1_r = wr_byte(st_r.amp1_r, wd, opctl_pkg::MASK_AMP);
        opctl_pkg::IDX_AMP_TWO:   st_nxt.amp2_r = wr_byte(st_r.amp2_r, wd, opctl_pkg::MASK_AMP);
        opctl_pkg::IDX_AMP_THREE: st_nxt.amp3_r = wr_byte(st_r.amp3_r, wd, opctl_pkg::MASK_AMP_THREE);
        opctl_pkg::IDX_CONV_SW:   st_nxt.conv_r = wr_byte(st_r.conv_r, wd, opctl_pkg::MASK_CONV_SW);
        default: begin
          for (int i = 0; i < NPINS; i++) begin
            if (idx == opctl_pkg::IDX_PIN_BASE + 6'(i)) begin
              st_nxt.pin_r[i] = wr_byte(st_r.pin_r[i], wd, pin_mask(i));
            end
          end
        end
      endcase
    end
    // Registered decode so every output is a flip-flop
    st_nxt.a1_r = amp_decode(st_nxt.amp1_r);
    st_nxt.a2_r = amp_decode(st_nxt.amp2_r);
    for (int i = 0; i < NPINS; i++) begin
      if (i < opctl_pkg::LOW_PINS) begin
        st_nxt.ps_r[i] = '0;
        st_nxt.ps_r[i].from_second_neg = st_nxt.pin_r[i][2];
        st_nxt.ps_r[i].from_first_neg  = st_nxt.pin_r[i][1];
      end else begin
        st_nxt.ps_r[i] = {2'b00, st_nxt.pin_r[i][3:0]};
      end
    end
  end

  // State register; all zero at reset leaves amps off, switches open
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.dat_r;
  assign wb_ack_o = st_r.ack_r;
  assign amp1_ctl = st_r.a1_r;
  assign amp2_ctl = st_r.a2_r;
  assign ref_ctl  = st_r.ref_r & opctl_pkg::MASK_REF_FLAG;
  assign amp3_ctl = st_r.amp3_r & opctl_pkg::MASK_AMP_THREE;
  assign conv_sw  = st_r.conv_r & opctl_pkg::MASK_CONV_SW;
  assign pin_sw   = st_r.ps_r;

  ack_single_a: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  ack_prompt_a: assert property (@(posedge ref_clk) disable iff (rst)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack next cycle");
  mode_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
    amp1_ctl.cal_mode == st_r.amp1_r[7]) else $error("mode bit misplaced");
  ref_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
    amp2_ctl.cal_ref_pos == st_r.amp2_r[6]) else $error("reference bit misplaced");
  cal_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    amp1_ctl.cal_active |-> amp1_ctl.cal_ref_pos && amp1_ctl.cal_mode)
    else $error("calibration without positive reference");
  enable_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
    amp2_ctl.enable == st_r.amp2_r[5]) else $error("enable bit misplaced");
  trim_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
    && wb_adr_i[7:2] == 6'h01 |=> amp1_ctl.trim_code == $past(wb_dat_i[4:0]))
    else $error("trim code not written");
  low_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
    pin_sw[0].from_second_pos == 1'b0 && pin_sw[0].from_first_out == 1'b0)
    else $error("low pin drives absent switch");
  high_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
    pin_sw[NPINS-1].from_first_out == st_r.pin_r[NPINS-1][0]) else $error("upper pin switch wrong");
  zero_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper read bits set");
  reset_zero_a: assert property (@(posedge ref_clk)
    $past(rst) |-> !amp1_ctl.enable && !amp2_ctl.enable && pin_sw == '0)
    else $error("not cleared by reset");
endmodule : opctl_regs

// ===== hw/opctl_pkg.sv
package opctl_pkg;
  // Register word offsets (byte address = 4 * index)
  localparam logic [5:0] IDX_REF_FLAG  = 6'h00;
  localparam logic [5:0] IDX_AMP_ONE   = 6'h01;
  localparam logic [5:0] IDX_AMP_TWO   = 6'h02;
  localparam logic [5:0] IDX_AMP_THREE = 6'h03;
  localparam logic [5:0] IDX_CONV_SW   = 6'h04;
  localparam logic [5:0] IDX_PIN_BASE  = 6'h08;
  localparam int         NUM_PINS      = 10;
  localparam int         LOW_PINS      = 5;
  localparam int         MID_LAST      = 7;
  // Field positions
  localparam int BIT_CAL_MODE  = 7;
  localparam int BIT_CAL_REF   = 6;
  localparam int BIT_ENABLE    = 5;
  localparam int BIT_FLAG_ONE  = 7;
  localparam int BIT_FLAG_TWO  = 5;
  localparam int TRIM_MSB      = 4;
  // Writable bit masks per register
  localparam logic [7:0] MASK_REF_FLAG  = 8'h13;
  localparam logic [7:0] MASK_AMP       = 8'hff;
  localparam logic [7:0] MASK_AMP_THREE = 8'hcf;
  localparam logic [7:0] MASK_CONV_SW   = 8'h8f;
  localparam logic [7:0] MASK_PIN_LOW   = 8'hfe;
  localparam logic [7:0] MASK_PIN_MID   = 8'hff;
  localparam logic [7:0] MASK_PIN_HIGH  = 8'h3f;
  localparam logic [7:0] RESET_VALUE    = 8'h00;
  localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

  // Controls presented to one analog amplifier
  typedef struct packed {
    logic       enable;
    logic       cal_mode;
    logic       cal_ref_pos;
    logic       cal_active;
    logic [4:0] trim_code;
  } opctl_amp_type;

  // Amplifier-related switches for one analog pin
  typedef struct packed {
    logic from_second_neg;
    logic from_first_neg;
    logic from_second_pos;
    logic from_second_out;
    logic from_first_pos;
    logic from_first_out;
  } opctl_pin_type;
endpackage : opctl_pkg

// ===== hw/opctl_flag.sv
`timescale 1ns/1ps
module opctl_flag (
  input  wire logic ref_clk,     // System clock
  input  wire logic rst,         // Synchronous reset
  input  wire logic cmp_async,   // Raw amplifier output level
  input  wire logic enable,      // Amplifier enabled
  input  wire logic cal_mode,    // Calibration mode selected
  output logic      flag         // Qualified output flag
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic flag;
  } opctl_flag_state_type;

  opctl_flag_state_type st_r;
  opctl_flag_state_type st_nxt;

  // Two-stage sync; only s2 feeds the flag
  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = cmp_async;
    st_nxt.s2   = st_r.s1;
    st_nxt.flag = enable & cal_mode & st_r.s2;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag;

  flag_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(enable) |-> !flag) else $error("flag set while amplifier disabled");
  flag_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
    $past(enable) && $past(cal_mode) |-> flag == $past(st_r.s2))
    else $error("flag does not follow amplifier output");
endmodule : opctl_flag

// ===== sim/test_opamp_control_regs.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin err_total++; \
  $display("unexpected %s: expected %h seen %h", nm, ex, gt); end end
module test_opamp_control_regs;
  logic                                ref_clk  = 1'b0;
  logic                                rst      = 1'b1;
  logic                                wb_cyc_i = 1'b0;
  logic                                wb_stb_i = 1'b0;
  logic                                wb_we_i  = 1'b0;
  logic [7:0]                          wb_adr_i = 8'h00;
  logic [3:0]                          wb_sel_i = 4'h0;
  logic [31:0]                         wb_dat_i = 32'h0000_0000;
  logic [31:0]                         wb_dat_o;
  logic                                wb_ack_o;
  logic                                amp1_out = 1'b0;
  logic                                amp2_out = 1'b0;
  opctl_pkg::opctl_amp_type            amp1_ctl;
  opctl_pkg::opctl_amp_type            amp2_ctl;
  logic [7:0]                          ref_ctl;
  logic [7:0]                          amp3_ctl;
  logic [7:0]                          conv_sw;
  opctl_pkg::opctl_pin_type [9:0]      pin_sw;
  logic [31:0]                         exp_q[$];
  logic [31:0]                         e_mon;
  int                                  err_total = 0;
  int                                  checked   = 0;
  // Plain registers: index and readable mask, unmapped places last
  logic [5:0]                          ri[6] = '{6'h00, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07};
  logic [7:0]                          rm[6] = '{8'h13, 8'hcf, 8'h8f, 8'h00, 8'h00, 8'h00};
  // Flag steps: control value, amplifier level, expected flag
  logic [9:0]                          ft[6] = '{10'h283, 10'h280, 10'h283, 10'h202, 10'h082, 10'h383};

  opctl_regs u_opctl_regs (
    .ref_clk (ref_clk), .rst (rst), .wb_cyc_i (wb_cyc_i), .wb_stb_i (wb_stb_i),
    .wb_we_i (wb_we_i), .wb_adr_i (wb_adr_i), .wb_sel_i (wb_sel_i), .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o), .wb_ack_o (wb_ack_o), .amp1_out (amp1_out), .amp2_out (amp2_out),
    .amp1_ctl (amp1_ctl), .amp2_ctl (amp2_ctl), .ref_ctl (ref_ctl), .amp3_ctl (amp3_ctl),
    .conv_sw (conv_sw), .pin_sw (pin_sw)
  );

  // Clock at 50 MHz
  always #10 ref_clk = ~ref_clk;

  task automatic wb_xfer(input logic we, input logic [3:0] sel, input logic [5:0] idx, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= sel;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    n = 0;
    // Hold the request until ack is seen at an edge
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    // A missing answer counts as a mismatch, not a silent skip
    if (n >= 50) err_total++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    wb_xfer(1'b1, 4'h1, idx, d);
  endtask : wr

  // Note is queued before the request, so the monitor always finds it
  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    wb_xfer(1'b0, 4'h1, idx, 8'h00);
  endtask : rd

  // One trim step of the software search, comparator trips at t
  task automatic trim_step(input logic [4:0] c, input logic [4:0] t);
    wr(opctl_pkg::IDX_AMP_ONE, {3'b111, c});
    amp1_out <= (c >= t);
    repeat (4) @(posedge ref_clk);
    rd(opctl_pkg::IDX_REF_FLAG, 8'h13 | {(c >= t), 7'h00});
  endtask : trim_step

  task automatic all_zero;
    for (int i = 0; i < 18; i++) rd(6'(i), 8'h00);
  endtask : all_zero

  task wrap_up;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // Read data monitor, oldest note first
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("unexpected read_ack: expected none seen %h", wb_dat_o);
      end else begin
        e_mon = exp_q.pop_front();
        `CHK("read_data", e_mon, wb_dat_o)
      end
    end
  end

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    wrap_up();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] m;
    logic [7:0] ref_v;
    logic [7:0] th_v;
    logic [4:0] thr;
    void'($urandom(32'h61e6));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    all_zero();
    ref_v = 8'h00;
    th_v  = 8'h00;
    // All ones into plain registers; read-only and missing bits stay zero
    for (int i = 0; i < 6; i++) begin
      wr(ri[i], 8'hff);
      rd(ri[i], rm[i]);
    end
    ref_v = 8'h13;
    th_v  = 8'hcf;
    `CHK("conv_sw", 8'h8f, conv_sw)
    `CHK("ref_ctl", 8'h13, ref_ctl)
    `CHK("amp3_ctl", 8'hcf, amp3_ctl)
    // Lane zero not selected: write must be dropped
    wb_xfer(1'b1, 4'he, opctl_pkg::IDX_CONV_SW, 8'h00);
    rd(opctl_pkg::IDX_CONV_SW, 8'h8f);
    // Pin switches with random patterns
    for (int p = 0; p < 10; p++) begin
      // One switch per pin at a time, so no nodes are shorted
      d = 8'h01 << ($urandom() % 8);
      m = p < 5 ? 8'hfe : (p < 8 ? 8'hff : 8'h3f);
      wr(6'(opctl_pkg::IDX_PIN_BASE + p), d);
      `CHK("pin_sw", p < 5 ? {d[2], d[1], 4'h0} : {2'b00, d[3:0]}, pin_sw[p])
      rd(6'(opctl_pkg::IDX_PIN_BASE + p), d & m);
    end
    // Every mode, reference and enable combination on both amplifiers
    for (int a = 0; a < 2; a++) begin
      for (int k = 0; k < 8; k++) begin
        d = {3'(k), 5'($urandom())};
        wr(a ? opctl_pkg::IDX_AMP_TWO : opctl_pkg::IDX_AMP_ONE, d);
        `CHK("amp_ctl", {d[5], d[7], d[6], d[7] & d[6] & d[5], d[4:0]}, a ? amp2_ctl : amp1_ctl)
        rd(a ? opctl_pkg::IDX_AMP_TWO : opctl_pkg::IDX_AMP_ONE, d);
      end
    end
    // Flags follow the amplifier only when enabled in calibration mode
    for (int a = 0; a < 2; a++) begin
      for (int k = 0; k < 6; k++) begin
        wr(a ? opctl_pkg::IDX_AMP_TWO : opctl_pkg::IDX_AMP_ONE, ft[k][9:2]);
        if (a) amp2_out <= ft[k][1];
        else amp1_out <= ft[k][1];
        repeat (5) @(posedge ref_clk);
        rd(a ? opctl_pkg::IDX_AMP_THREE : opctl_pkg::IDX_REF_FLAG,
           a ? th_v | {2'b00, ft[k][0], 5'h00} : ref_v | {ft[k][0], 7'h00});
      end
    end
    // Trim search up from zeros and down from ones, average written back
    thr = 5'(1 + $urandom() % 31);
    for (int c = 0; c <= thr; c++) trim_step(5'(c), thr);
    for (int c = 31; c >= thr - 1; c--) trim_step(5'(c), thr);
    wr(opctl_pkg::IDX_AMP_ONE, {3'b111, 5'((2 * thr - 1) / 2)});
    `CHK("trim_avg", 5'((2 * thr - 1) / 2), amp1_ctl.trim_code)
    // Reset again in mid-run: everything back to zero
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    all_zero();
    `CHK("pin_sw_reset", 60'h0, pin_sw)
    repeat (3) @(posedge ref_clk);
    wrap_up();
  end
endmodule : test_opamp_control_regs
